/* inc/rtc_ctrl_regs.vh */
// Register map, field positions and timing constants of the timekeeper
// Overview of operation
// - Bit 7 holds block reset; release two cycles later
// - Count only when enabled; first increment after 64 edges
// - Disable stops prescaler, keeps the count
// - Preload accepted only while counting disabled
// - Wake-on-match set: both match outputs follow equality
// - Wake-on-match clear: both match outputs held low
// - Mode field bits 4:3 drives crystal mode output
// - Clear-on-match clears counter synchronously on equality
// - No clear-on-match when match value is zero
// - Writing counter-reset bit low clears 40-bit count
// - Crystal-enable bit drives crystal select output
// - Crystal enabled: oscillator mode from mode field
// - Divide counter clock by 128 before counting
// - Count bytes 1-4 are read from a read-hold register; byte 0 reads the live count
// - Control/status register at address 0x58
`ifndef RTC_CTRL_REGS_VH
`define RTC_CTRL_REGS_VH
`define ADDR_COUNT0 8'h40
`define ADDR_COUNT4 8'h44
`define ADDR_MATCH0 8'h48
`define ADDR_MATCH4 8'h4C
`define ADDR_MBIT0 8'h50
`define ADDR_MBIT4 8'h54
`define ADDR_CTRL 8'h58
`define CTRL_RESET 8'h00
`define BIT_BLK_RST 7
`define BIT_CNT_EN 6
`define BIT_WAKE 5
`define FLD_MODE_HI 4
`define FLD_MODE_LO 3
`define BIT_CLR_MAT 2
`define BIT_CNT_RSTN 1
`define BIT_XTAL_EN 0
`define RST_RELEASE_CYC 2'h2
`define FIRST_INC_EDGES 8'h40
`define PRESCALE_DIV 8'h80
`define CNT_BYTES 5
`define BYTE_SEL_HI 2
`define SYNC_CCLK 0
`endif

/* src/level_sync.v */
// Three-stage synchroniser; output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  input wire ce,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  integer i;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= {W{1'b0}};
      s2_ff <= {W{1'b0}};
      s3_ff <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_ff[i] == s3_ff[i]) begin
          q[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule // level_sync
`default_nettype wire

/* src/rtc_prescaler.v */
// Counter-clock prescaler producing one advance strobe per period
`timescale 1ns/1ps
`default_nettype none
`include "rtc_ctrl_regs.vh"
module rtc_prescaler #(
  parameter DIV = 128,
  parameter FIRST = 64
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  input wire ce,
  // Control
  input wire run,
  input wire blk_rst,
  input wire edge_in,
  output reg tick
);
  reg [7:0] cnt_ff;
  reg started_ff;
  wire [7:0] limit;
  // First period is shorter so the first advance lands after FIRST edges
  assign limit = started_ff ? DIV[7:0] : FIRST[7:0];
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 8'h00;
      started_ff <= 1'b0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (blk_rst || !run) begin
        // Halted; the count elsewhere is kept on disable but cleared on block reset
        cnt_ff <= 8'h00;
        started_ff <= 1'b0;
      end else if (edge_in) begin
        if (cnt_ff == limit - 8'h01) begin
          cnt_ff <= 8'h00;
          started_ff <= 1'b1;
          tick <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end
  end
endmodule // rtc_prescaler
`default_nettype wire

/* src/rtc_control_status_logic.v */
// Timekeeper control/status register, 40-bit counter and match logic
`timescale 1ns/1ps
`default_nettype none
`include "rtc_ctrl_regs.vh"
module rtc_control_status_logic #(
  parameter CW = 40
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  input wire ce,
  // Configuration byte port
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wdata,
  input wire cfg_wen,
  input wire cfg_ren,
  output reg [7:0] cfg_rdata,
  // Crystal side
  input wire counter_clock,
  output reg [1:0] crystal_mode_out,
  output reg crystal_select_out,
  // Match outputs
  output reg fabric_match_out,
  output reg power_monitor_match_out
);
  reg [7:0] ctrl_ff;
  reg [1:0] rst_dly_ff;
  reg blk_rst_ff;
  reg [CW-1:0] count_ff;
  reg [CW-1:0] match_ff;
  reg [CW-1:0] hold_ff;
  reg cclk_prev_ff;
  wire [7:0] sync_in;
  wire [7:0] sync_out;
  wire cclk_s;
  wire tick;
  wire run;
  wire equal;
  wire match_zero;
  wire [CW-1:0] mbits;
  wire [2:0] bsel;
  wire in_cnt;
  wire in_mat;
  wire in_bit;
  reg [7:0] nxt_rdata;

  // Control bits and counter clock both arrive from other domains
  // Bit 0 of the synchroniser carries the counter clock, not crystal enable
  assign sync_in = {ctrl_ff[`BIT_BLK_RST:`BIT_CNT_RSTN], counter_clock};
  level_sync #(.W(8)) u_sync (
    .clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .d(sync_in),
    .q(sync_out)
  );
  assign cclk_s = sync_out[`SYNC_CCLK];
  assign run = sync_out[`BIT_CNT_EN] && !blk_rst_ff;

  rtc_prescaler #(.DIV(`PRESCALE_DIV), .FIRST(`FIRST_INC_EDGES)) u_pre (
    .clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .run(run),
    .blk_rst(blk_rst_ff),
    .edge_in(cclk_s && !cclk_prev_ff),
    .tick(tick)
  );

  assign bsel = cfg_addr[`BYTE_SEL_HI:0];
  assign in_cnt = cfg_addr >= `ADDR_COUNT0 && cfg_addr <= `ADDR_COUNT4;
  assign in_mat = cfg_addr >= `ADDR_MATCH0 && cfg_addr <= `ADDR_MATCH4;
  assign in_bit = cfg_addr >= `ADDR_MBIT0 && cfg_addr <= `ADDR_MBIT4;
  assign mbits = ~(count_ff ^ match_ff);
  assign equal = &mbits;
  assign match_zero = ~|match_ff;

  // Control register, block-reset release delay
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= `CTRL_RESET;
      rst_dly_ff <= 2'h0;
      blk_rst_ff <= 1'b0;
      cclk_prev_ff <= 1'b0;
    end else if (ce) begin
      cclk_prev_ff <= cclk_s;
      if (cfg_wen && cfg_addr == `ADDR_CTRL) begin
        ctrl_ff <= cfg_wdata;
      end
      if (ctrl_ff[`BIT_BLK_RST]) begin
        blk_rst_ff <= 1'b1;
        rst_dly_ff <= 2'h0;
      end else if (blk_rst_ff) begin
        if (rst_dly_ff == `RST_RELEASE_CYC - 2'h1) begin
          blk_rst_ff <= 1'b0;
        end else begin
          rst_dly_ff <= rst_dly_ff + 2'h1;
        end
      end
    end
  end

  // Counter and match registers
  genvar g;
  generate
    for (g = 0; g < `CNT_BYTES; g = g + 1) begin : g_byte
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          match_ff[g*8+7:g*8] <= 8'h00;
        end else if (ce) begin
          if (blk_rst_ff) begin
            match_ff[g*8+7:g*8] <= 8'h00;
          end else if (cfg_wen && in_mat && bsel == g) begin
            match_ff[g*8+7:g*8] <= cfg_wdata;
          end
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_ff <= {CW{1'b0}};
    end else if (ce) begin
      if (blk_rst_ff || !sync_out[`BIT_CNT_RSTN]) begin
        count_ff <= {CW{1'b0}};
      end else if (!sync_out[`BIT_CNT_EN] && cfg_wen && in_cnt) begin
        // Preloads while running are ignored to avoid torn counts
        count_ff[bsel*8 +: 8] <= cfg_wdata;
      end else if (tick) begin
        if (sync_out[`BIT_CLR_MAT] && equal && !match_zero) begin
          count_ff <= {CW{1'b0}};
        end else begin
          count_ff <= count_ff + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Read-hold: snapshot taken on reading the low byte
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_ff <= {CW{1'b0}};
    end else if (ce && cfg_ren && cfg_addr == `ADDR_COUNT0) begin
      hold_ff <= count_ff;
    end
  end

  always @* begin
    nxt_rdata = 8'h00;
    if (in_cnt) begin
      if (bsel == 3'h0) begin
        nxt_rdata = count_ff[7:0];
      end else begin
        nxt_rdata = hold_ff[bsel*8 +: 8];
      end
    end else if (in_mat) begin
      nxt_rdata = match_ff[bsel*8 +: 8];
    end else if (in_bit) begin
      nxt_rdata = mbits[bsel*8 +: 8];
    end else if (cfg_addr == `ADDR_CTRL) begin
      nxt_rdata = {blk_rst_ff, ctrl_ff[`BIT_CNT_EN:0]};
    end
  end

  // Registered outputs
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= 8'h00;
      crystal_mode_out <= 2'h0;
      crystal_select_out <= 1'b0;
      fabric_match_out <= 1'b0;
      power_monitor_match_out <= 1'b0;
    end else if (ce) begin
      if (cfg_ren) begin
        cfg_rdata <= nxt_rdata;
      end
      crystal_mode_out <= ctrl_ff[`FLD_MODE_HI:`FLD_MODE_LO];
      crystal_select_out <= ctrl_ff[`BIT_XTAL_EN];
      fabric_match_out <= sync_out[`BIT_WAKE] && equal;
      power_monitor_match_out <= sync_out[`BIT_WAKE] && equal;
    end
  end
endmodule // rtc_control_status_logic
`default_nettype wire

/* verification/rtc_ctrl_assertions.sv */
// Assertion checker for the timekeeper control/status block
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // Config port
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wen,
  input wire logic cfg_ren,
  input wire logic [7:0] cfg_rdata,
  // Crystal and match
  input wire logic [1:0] crystal_mode_out,
  input wire logic crystal_select_out,
  input wire logic fabric_match_out,
  input wire logic power_monitor_match_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Strobes only count while the clock enable lets the design take them
  wire cw = ce && cfg_wen && cfg_addr == 8'h58;
  wire cr = ce && cfg_ren && cfg_addr == 8'h58;
  match_pair_a:
    assert property (fabric_match_out == power_monitor_match_out)
    else $error("match outputs differ");
  wake_off_a:
    assert property (cw && !cfg_wdata[5] ##1 !cfg_wen [*8] |->
      !fabric_match_out) else $error("match high with wake off");
  sel_follow_a:
    assert property (cw |-> ##2 crystal_select_out == $past(cfg_wdata[0], 2))
    else $error("select not following bit 0");
  mode_follow_a:
    assert property (cw |-> ##2 crystal_mode_out == $past(cfg_wdata[4:3], 2))
    else $error("mode not following field");
  reset_zero_a:
    assert property ($rose(rstn) |-> crystal_mode_out == 2'h0 &&
      !crystal_select_out && !fabric_match_out) else $error("bad reset");
  rdata_hold_a:
    assert property (!(ce && cfg_ren) |=> $stable(cfg_rdata))
    else $error("read data moved without read");
  unmapped_zero_a:
    assert property (ce && cfg_ren && cfg_addr == 8'h60 |=>
      cfg_rdata == 8'h00) else $error("unmapped read not zero");
  ctrl_readback_a:
    assert property (cr |=> cfg_rdata[4:3] == crystal_mode_out &&
      cfg_rdata[0] == crystal_select_out) else $error("ctrl readback");
  blk_status_a:
    assert property (cw && cfg_wdata[7] ##2 cr |=> cfg_rdata[7])
    else $error("block reset status not shown");
endmodule // rtc_ctrl_checker
bind rtc_control_status_logic rtc_ctrl_checker chk_u (.ref_clk(ref_clk),
  .rstn(rstn), .ce(ce), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
  .cfg_wen(cfg_wen),
  .cfg_ren(cfg_ren), .cfg_rdata(cfg_rdata),
  .crystal_mode_out(crystal_mode_out),
  .crystal_select_out(crystal_select_out),
  .fabric_match_out(fabric_match_out),
  .power_monitor_match_out(power_monitor_match_out));
`default_nettype wire

/* verification/crystal_model.sv */
// Crystal oscillator stand-in driving the counter clock
`timescale 1ns/1ps
`default_nettype none
module crystal_model #(
  parameter HALF_NS = 50
) (
  // Clock out
  output var logic counter_clock
);
  // Runs free: a crystal does not stop between register accesses
  initial begin
    counter_clock = 1'b0;
    forever #(HALF_NS) counter_clock = ~counter_clock;
  end
endmodule // crystal_model
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the timekeeper control/status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, rstn, ce, cfg_wen, cfg_ren, rd_pend;
  logic [7:0] cfg_addr, cfg_wdata, d, r;
  wire [7:0] cfg_rdata;
  wire [1:0] crystal_mode_out;
  wire counter_clock, crystal_select_out;
  wire fabric_match_out, power_monitor_match_out;
  logic [7:0] exp_q[$];
  integer fail_count = 0, cmp_count = 0, seed = 17, i;
  crystal_model xtal_u (.counter_clock(counter_clock));
  rtc_control_status_logic dut_u (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wen(cfg_wen),
    .cfg_ren(cfg_ren), .cfg_rdata(cfg_rdata), .counter_clock(counter_clock),
    .crystal_mode_out(crystal_mode_out),
    .crystal_select_out(crystal_select_out),
    .fabric_match_out(fabric_match_out),
    .power_monitor_match_out(power_monitor_match_out));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task end_of_test;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // A read notes its expected byte; the monitor below compares it
  task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    if (!w) exp_q.push_back(v);
    cfg_addr <= a;
    cfg_wdata <= v;
    cfg_wen <= w;
    cfg_ren <= !w;
    @(posedge ref_clk);
    cfg_wen <= 1'b0;
    cfg_ren <= 1'b0;
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (rd_pend) chk(cfg_rdata, exp_q.pop_front());
    rd_pend <= cfg_ren;
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    cfg_wen = 1'b0;
    cfg_ren = 1'b0;
    rd_pend = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(0, 8'h58, 8'h00);
    bus(0, 8'h60, 8'h00);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      d = {3'b000, i[1:0], 2'b00, r[0]};
      bus(1, 8'h58, d);
      bus(0, 8'h58, d);
      chk({6'h00, crystal_mode_out}, {6'h00, d[4:3]});
      chk({7'h00, crystal_select_out}, {7'h00, d[0]});
    end
    $display("test crystal done");
    // Counter-reset release needs the sync delay before a preload lands
    bus(1, 8'h58, 8'h02);
    repeat (4) @(posedge ref_clk);
    bus(1, 8'h40, 8'h05);
    bus(1, 8'h48, 8'h06);
    bus(0, 8'h40, 8'h05);
    // Crystal selected in the same write as the wake-up setup, as standby needs
    bus(1, 8'h58, 8'h63);
    repeat (8) @(posedge ref_clk);
    // Preload while running must be refused
    bus(1, 8'h40, 8'h00);
    repeat (480) @(posedge ref_clk);
    bus(0, 8'h40, 8'h05);
    for (i = 0; i < 3000 && fabric_match_out !== 1'b1; i++)
      @(posedge ref_clk);
    if (fabric_match_out !== 1'b1) begin
      fail_count++;
    end else begin
      chk({7'h00, power_monitor_match_out}, 8'h01);
      bus(1, 8'h58, 8'h22);
      repeat (8) @(posedge ref_clk);
      bus(0, 8'h40, 8'h06);
      bus(1, 8'h58, 8'h02);
      repeat (8) @(posedge ref_clk);
      chk({7'h00, fabric_match_out}, 8'h00);
      bus(1, 8'h58, 8'h00);
      repeat (8) @(posedge ref_clk);
      bus(0, 8'h40, 8'h00);
      $display("test count done");
      // Second tick meets count 6 == match 6 and must clear, not reach 7
      bus(1, 8'h58, 8'h02);
      repeat (4) @(posedge ref_clk);
      bus(1, 8'h40, 8'h05);
      bus(1, 8'h58, 8'h46);
      repeat (2500) @(posedge ref_clk);
      bus(0, 8'h40, 8'h00);
      $display("test clear done");
      bus(1, 8'h58, 8'h80);
      bus(0, 8'h58, 8'h80);
      bus(0, 8'h48, 8'h00);
      bus(1, 8'h58, 8'h00);
      // Status still shows reset two edges after the bit is cleared
      bus(0, 8'h58, 8'h80);
      bus(0, 8'h58, 8'h00);
      $display("test block reset done");
      // Match is zero now, so the clear is suppressed at the first tick
      bus(1, 8'h58, 8'h46);
      repeat (900) @(posedge ref_clk);
      bus(0, 8'h40, 8'h01);
      $display("test zero match done");
      // A write while the clock enable is low must leave no trace
      ce <= 1'b0;
      bus(1, 8'h48, 8'h33);
      ce <= 1'b1;
      bus(0, 8'h48, 8'h00);
      $display("test freeze done");
      bus(1, 8'h58, 8'h00);
      repeat (2) @(posedge ref_clk);
    end
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
